//--- logic/aid_pkg.sv
`default_nettype none
package aid_pkg;
  // single-byte opcodes
  localparam logic [7:0] OP_ROT_L  = 8'h23;
  localparam logic [7:0] OP_ROT_LC = 8'h33;
  localparam logic [7:0] OP_ROT_R  = 8'h03;
  localparam logic [7:0] OP_ROT_RC = 8'h13;
  localparam logic [7:0] OP_SWAP   = 8'hC4;
  localparam logic [7:0] OP_MULT   = 8'hA4;
  localparam logic [7:0] OP_DIV    = 8'h84;
  // high nibble of each operation group
  localparam logic [3:0] HI_ADD    = 4'h2;
  localparam logic [3:0] HI_ADD_CY = 4'h3;
  localparam logic [3:0] HI_SUB_BW = 4'h9;
  localparam logic [3:0] HI_AND    = 4'h5;
  localparam logic [3:0] HI_OR     = 4'h4;
  localparam logic [3:0] HI_XOR    = 4'h6;
  // low nibble of the addressing forms
  localparam logic [3:0] LO_DIR_ACC = 4'h2;
  localparam logic [3:0] LO_DIR_IMM = 4'h3;
  localparam logic [3:0] LO_IMM     = 4'h4;
  localparam logic [3:0] LO_DIR     = 4'h5;
  localparam logic [2:0] LO_IND     = 3'h3;  // low nibble 6 or 7
  localparam int         REG_BIT    = 3;     // low nibble 8..F
  // lengths, machine cycles, addresses, reset values
  localparam logic [1:0] LEN_1      = 2'h1;
  localparam logic [1:0] LEN_2      = 2'h2;
  localparam logic [1:0] LEN_3      = 2'h3;
  localparam logic [2:0] CYC_1      = 3'h1;
  localparam logic [2:0] CYC_2      = 3'h2;
  localparam logic [2:0] CYC_MULDIV = 3'h4;
  localparam logic [7:0] ADDR_B     = 8'hF0;
  localparam logic [7:0] RST_ACC    = 8'h00;

  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_ADD_CY, ALU_SUB_BW, ALU_AND, ALU_OR, ALU_XOR,
    ALU_ROT_L, ALU_ROT_LC, ALU_ROT_R, ALU_ROT_RC, ALU_SWAP, ALU_MULT, ALU_DIV
  } aid_alu_t;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM, SRC_ACC
  } aid_kind_t;
  typedef enum logic [2:0] {
    ST_OPC = 3'h0, ST_OP1 = 3'h1, ST_OP2 = 3'h3,
    ST_EXEC = 3'h2, ST_WAIT = 3'h6
  } aid_state_t;

  typedef struct packed { logic valid; logic [7:0] data; } aid_code_t;
  typedef struct packed {
    aid_kind_t  kind;
    logic [2:0] index;
    logic       ptr_sel;
    logic [7:0] addr;
  } aid_src_t;
  typedef struct packed {
    logic valid; logic [7:0] addr; logic [7:0] data;
  } aid_wr_t;
  typedef struct packed {
    logic valid; logic [7:0] opcode; logic [1:0] bytes;
    logic [2:0] cycles; logic legal;
  } aid_done_t;
  typedef struct packed { logic carry; logic aux; logic ovf; } aid_flags_t;
  typedef struct packed {
    aid_alu_t   alu; aid_kind_t kind; logic to_dir;
    logic [1:0] bytes; logic [2:0] cycles; logic legal;
  } aid_dec_t;
  typedef struct packed {
    aid_state_t st;
    logic [7:0] opcode, op1, op2, acc, a_old;
    logic       c_old;
    aid_flags_t flags;
    logic [1:0] left;
    aid_wr_t    wr;
    aid_done_t  done;
  } aid_regs_t;
endpackage
`default_nettype wire

//--- logic/aid_alu_decode.sv
`timescale 1ns/10ps
`default_nettype none
module aid_alu_decode
  import aid_pkg::*;
(
  // clock and reset
  input  wire logic      i_clock,
  input  wire logic      i_reset_n,
  // program memory bytes
  input  wire aid_code_t i_code,
  output logic           o_code_ready,
  // operand fetch and result write
  output aid_src_t       o_src,
  input  wire logic [7:0] i_src_data,
  input  wire logic [7:0] i_b_data,
  output aid_wr_t        o_wr,
  // core state
  output logic [7:0]     o_acc,
  output aid_flags_t     o_flags,
  output aid_done_t      o_done
);
  aid_regs_t s, n;
  aid_dec_t  d, d_in;
  logic [7:0] a, b, res, bres;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [15:0] prod;
  aid_flags_t fl;

  // opcode to operation, length and cycle count
  function automatic aid_dec_t decode(input logic [7:0] op);
    aid_dec_t r;
    r = '{ALU_NONE, SRC_NONE, 1'b0, LEN_1, CYC_1, 1'b1};
    case (op[7:4])
      HI_ADD:    r.alu = ALU_ADD;
      HI_ADD_CY: r.alu = ALU_ADD_CY;
      HI_SUB_BW: r.alu = ALU_SUB_BW;
      HI_AND:    r.alu = ALU_AND;
      HI_OR:     r.alu = ALU_OR;
      HI_XOR:    r.alu = ALU_XOR;
      default: r.alu = ALU_NONE;
    endcase
    if (r.alu != ALU_NONE)
    begin
      if (op[REG_BIT])
        r.kind = SRC_REG;
      else if (op[2:0] == LO_DIR[2:0])
        begin r.kind = SRC_DIR; r.bytes = LEN_2; end
      else if (op[2:1] == LO_IND[1:0] && op[3:1] == LO_IND)
        r.kind = SRC_IND;
      else if (op[3:0] == LO_IMM)
        begin r.kind = SRC_IMM; r.bytes = LEN_2; end
      else if (op[3:0] == LO_DIR_ACC && r.alu >= ALU_AND)
      begin
        r.kind = SRC_ACC;
        r.to_dir = 1'b1;
        r.bytes = LEN_2;
      end
      else if (op[3:0] == LO_DIR_IMM && r.alu >= ALU_AND)
      begin
        r.kind = SRC_IMM;
        r.to_dir = 1'b1;
        r.bytes = LEN_3;
        r.cycles = CYC_2;
      end
      else
        r.alu = ALU_NONE;
    end
    if (r.alu == ALU_NONE)  // rotates 23 and 33 share the add nibbles
    begin
      case (op)
        OP_ROT_L:  r.alu = ALU_ROT_L;
        OP_ROT_LC: r.alu = ALU_ROT_LC;
        OP_ROT_R:  r.alu = ALU_ROT_R;
        OP_ROT_RC: r.alu = ALU_ROT_RC;
        OP_SWAP:   r.alu = ALU_SWAP;
        OP_MULT:   begin r.alu = ALU_MULT; r.cycles = CYC_MULDIV; end
        OP_DIV:    begin r.alu = ALU_DIV; r.cycles = CYC_MULDIV; end
        default: r.legal = 1'b0;      // other groups pass as no-ops
      endcase
    end
    return r;
  endfunction

  assign d    = decode(s.opcode);
  assign d_in = decode(i_code.data);

  // operand address comes straight from the held opcode bytes
  always_comb
  begin
    o_src.kind    = d.kind;
    o_src.index   = s.opcode[2:0];
    o_src.ptr_sel = s.opcode[0];
    o_src.addr    = s.op1;
  end

  // datapath: destination value and second operand
  always_comb
  begin
    a    = d.to_dir ? i_src_data : s.acc;
    b    = (d.kind == SRC_IMM) ? ((d.bytes == LEN_3) ? s.op2 : s.op1)
         : (d.kind == SRC_ACC) ? s.acc : i_src_data;
    fl   = s.flags;
    res  = a;
    bres = i_b_data;
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'(a) * 16'(i_b_data);
    case (d.alu)
      ALU_ADD, ALU_ADD_CY:
      begin
        sum9 = {1'b0, a} + {1'b0, b}
             + {8'h00, d.alu == ALU_ADD_CY && s.flags.carry};
        nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]}
             + {4'h0, d.alu == ALU_ADD_CY && s.flags.carry};
        res  = sum9[7:0];
        fl   = '{sum9[8], nib5[4],
                 (a[7] == b[7]) && (sum9[7] != a[7])};
      end
      ALU_SUB_BW:
      begin
        sum9 = {1'b0, a} - {1'b0, b} - {8'h00, s.flags.carry};
        nib5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, s.flags.carry};
        res  = sum9[7:0];
        fl   = '{sum9[8], nib5[4],
                 (a[7] != b[7]) && (sum9[7] != a[7])};
      end
      ALU_AND:  res = a & b;
      ALU_OR:   res = a | b;
      ALU_XOR:  res = a ^ b;
      ALU_ROT_L:  res = {a[6:0], a[7]};
      ALU_ROT_LC: {fl.carry, res} = {a, s.flags.carry};
      ALU_ROT_R:  res = {a[0], a[7:1]};
      ALU_ROT_RC: {res, fl.carry} = {s.flags.carry, a};
      ALU_SWAP:   res = {a[3:0], a[7:4]};
      ALU_MULT:
      begin
        {bres, res} = prod;
        fl.carry = 1'b0;
        fl.ovf = (prod[15:8] != 8'h00);
      end
      ALU_DIV:
      begin
        // a zero divisor flags overflow and leaves A and B alone
        fl.carry = 1'b0;
        fl.ovf = (i_b_data == 8'h00);
        if (i_b_data != 8'h00)
        begin
          res  = a / i_b_data;
          bres = a % i_b_data;
        end
      end
      default: res = a;
    endcase
  end

  // sequencer: collect bytes, execute, then hold for extra cycles
  always_comb
  begin
    n = s;
    n.wr.valid = 1'b0;
    n.done.valid = 1'b0;
    case (s.st)
      ST_OPC:
        if (i_code.valid)
        begin
          n.opcode = i_code.data;
          n.st = (d_in.bytes == LEN_1) ? ST_EXEC : ST_OP1;
        end
      ST_OP1:
        if (i_code.valid)
        begin
          n.op1 = i_code.data;
          n.st = (d.bytes == LEN_3) ? ST_OP2 : ST_EXEC;
        end
      ST_OP2:
        if (i_code.valid)
        begin
          n.op2 = i_code.data;
          n.st = ST_EXEC;
        end
      ST_EXEC:
      begin
        n.a_old = s.acc;
        n.c_old = s.flags.carry;
        n.flags = fl;
        if (d.to_dir)
          n.wr = '{1'b1, s.op1, res};
        else
          n.acc = res;
        if (d.alu == ALU_MULT || d.alu == ALU_DIV)
          n.wr = '{1'b1, ADDR_B, bres};
        n.left = 2'(d.cycles - CYC_1);
        n.done = '{1'b0, s.opcode, d.bytes, d.cycles, d.legal};
        if (d.cycles == CYC_1)
        begin
          n.done.valid = 1'b1;
          n.st = ST_OPC;
        end
        else
          n.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        n.left = s.left - 2'h1;
        if (s.left == 2'h1)
        begin
          n.done.valid = 1'b1;
          n.st = ST_OPC;
        end
      end
      default: n.st = ST_OPC;
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      s <= '0;
      s.st <= ST_OPC;
      s.acc <= RST_ACC;
    end
    else
      s <= n;
  end

  assign o_code_ready = (s.st == ST_OPC) || (s.st == ST_OP1)
                     || (s.st == ST_OP2);
  assign o_wr    = s.wr;
  assign o_acc   = s.acc;
  assign o_flags = s.flags;
  assign o_done  = s.done;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_exec_muldiv;
    s.st == ST_EXEC && (s.opcode == OP_MULT || s.opcode == OP_DIV);
  endsequence
  sequence s_four_cycles;
    ##1 !o_done.valid [*3] ##1 o_done.valid;
  endsequence
  a_muldiv_four_cycles: assert property (s_exec_muldiv |-> s_four_cycles)
    else $error("multiply or divide did not take four cycles");
  a_add_imm_value: assert property (o_done.valid && o_done.opcode == 8'h24
    |-> o_acc == 8'(s.a_old + s.op1) && o_done.bytes == LEN_2)
    else $error("add immediate result wrong");
  a_add_with_carry_carry_in: assert property (o_done.valid && o_done.opcode == 8'h34
    |-> o_acc == 8'(s.a_old + s.op1 + {7'h00, s.c_old}))
    else $error("add with carry result wrong");
  a_subtract_with_borrow_imm_value: assert property (o_done.valid && o_done.opcode == 8'h94
    |-> o_acc == 8'(s.a_old - s.op1 - {7'h00, s.c_old})
        && o_done.bytes == LEN_2)
    else $error("subtract immediate wrong");
  a_dir_imm_shape: assert property (o_done.valid
    && o_done.opcode inside {8'h43, 8'h53, 8'h63}
    |-> o_done.bytes == LEN_3 && o_done.cycles == CYC_2)
    else $error("direct immediate logic length wrong");
  a_dir_write_pulse: assert property (s.st == ST_EXEC && d.to_dir
    |=> o_wr.valid && o_wr.addr == $past(s.op1))
    else $error("direct destination not written");
  a_rotate_left: assert property (o_done.valid && o_done.opcode == OP_ROT_LC
    |-> {o_flags.carry, o_acc} == {s.a_old, s.c_old})
    else $error("rotate left through carry wrong");
  a_rotate_right: assert property (o_done.valid && o_done.opcode == OP_ROT_R
    |-> o_acc == {s.a_old[0], s.a_old[7:1]})
    else $error("rotate right wrong");
  a_swap_nibbles: assert property (o_done.valid && o_done.opcode == OP_SWAP
    |-> o_acc == {s.a_old[3:0], s.a_old[7:4]})
    else $error("nibble swap wrong");
  a_reg_select: assert property (s.st == ST_EXEC && s.opcode[3]
    && d.alu != ALU_NONE |-> o_src.kind == SRC_REG && d.bytes == LEN_1)
    else $error("working register select wrong");
  a_add_carry_out: assert property (o_done.valid && o_done.opcode == 8'h24
    |-> o_flags.carry == (({1'b0, s.a_old} + {1'b0, s.op1}) > 9'h0FF))
    else $error("add carry flag wrong");
  a_busy_no_fetch: assert property (s.st inside {ST_EXEC, ST_WAIT}
    |-> !o_code_ready)
    else $error("code taken while executing");
endmodule
`default_nettype wire

//--- sim/aid_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module aid_mem_model
  import aid_pkg::*;
(
  // clock
  input  wire logic     i_clock,
  // operand request and reply
  input  wire aid_src_t i_src,
  output logic [7:0]    o_src_data,
  output logic [7:0]    o_b_data
);
  logic [7:0] junk = 8'hA5;

  // idle pattern flips each cycle so a stale read never passes for data
  always_ff @(posedge i_clock)
    junk <= ~junk;

  // fixed memory image, simple enough for the bench to predict
  always_comb
    case (i_src.kind)
      SRC_NONE: o_src_data = junk;
      SRC_REG:  o_src_data = 8'h81 + {5'h00, i_src.index};
      SRC_IND:  o_src_data = i_src.ptr_sel ? 8'h3C : 8'hC3;
      default:  o_src_data = i_src.addr ^ 8'h5A;
    endcase

  // b register holds a divisor that leaves remainders
  assign o_b_data = 8'h07;
endmodule
`default_nettype wire

//--- sim/test_alu_instruction_decode.sv
`timescale 1ns/10ps
`default_nettype none
module test_alu_instruction_decode
  import aid_pkg::*;
;
  logic       i_clock = 1'b0;
  logic       i_reset_n = 1'b0;
  aid_code_t  code = '0;
  logic       ready;
  aid_src_t   src;
  logic [7:0] sdat, bdat, acc;
  aid_wr_t    wr;
  aid_flags_t flags;
  aid_done_t  done;
  int         errors = 0;
  int         samples_checked = 0;
  logic [7:0] ea = 8'h00;  // expected accumulator
  aid_flags_t ef = '0;     // expected flags

  // 200 MHz clock
  always #2.5 i_clock = ~i_clock;

  aid_alu_decode i_dut (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_code      (code),
    .o_code_ready(ready),
    .o_src       (src),
    .i_src_data  (sdat),
    .i_b_data    (bdat),
    .o_wr        (wr),
    .o_acc       (acc),
    .o_flags     (flags),
    .o_done      (done)
  );

  aid_mem_model i_mem (
    .i_clock   (i_clock),
    .i_src     (src),
    .o_src_data(sdat),
    .o_b_data  (bdat)
  );

  task automatic check(input string what, input logic [19:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // predict, run and judge one instruction
  task automatic step(input logic [7:0] op, b1, b2);
    logic [3:0] hi, lo;
    logic [7:0] s, d, t2, r;
    logic [8:0] t;
    logic [1:0] n;
    logic [2:0] cy;
    logic       cin, ar, lg, el;
    aid_wr_t    ew, seen_wr;
    logic [7:0] bytes [3];
    int         k;
    hi = op[7:4];
    lo = op[3:0];
    bytes = '{op, b1, b2};
    {n, cy, ar, lg, el, ew, seen_wr} = {2'h1, 3'h1, 3'b001, 17'h0, 17'h0};
    s = lo[3] ? 8'h81 + {5'h00, lo[2:0]}
      : lo[3:1] == 3'h3 ? (lo[0] ? 8'h3C : 8'hC3)
      : lo == 4'h5 ? b1 ^ 8'h5A : b1;
    case (op)
      8'h23: ea = {ea[6:0], ea[7]};
      8'h33: {ef.carry, ea} = {ea, ef.carry};
      8'h03: ea = {ea[0], ea[7:1]};
      8'h13: {ea, ef.carry} = {ef.carry, ea};
      8'hC4: ea = {ea[3:0], ea[7:4]};
      8'hA4:
      begin
        {r, ea} = ea * 8'h07;
        {ef.carry, ef.ovf, cy, ew} = {1'b0, r != 8'h00, 3'h4, 1'b1, ADDR_B, r};
      end
      8'h84:
      begin
        r = ea % 8'h07;
        ea = ea / 8'h07;
        {ef.carry, ef.ovf, cy, ew} = {2'b00, 3'h4, 1'b1, ADDR_B, r};
      end
      default:
      begin
        ar = hi inside {4'h2, 4'h3, 4'h9} && lo >= 4'h4;
        lg = hi inside {4'h4, 4'h5, 4'h6} && lo >= 4'h2;
        el = ar || lg;
        if (el && lo inside {4'h2, 4'h4, 4'h5})
          n = 2'h2;
        if (el && lo == 4'h3)
          {n, cy} = {2'h3, 3'h2};
        d = lo[3:1] == 3'h1 ? b1 ^ 8'h5A : ea;
        t2 = lo == 4'h3 ? b2 : lo == 4'h2 ? ea : s;
        cin = hi inside {4'h3, 4'h9} ? ef.carry : 1'b0;
        // borrow and carry share the same flag
        if (ar)
        begin
          t = hi == 4'h9 ? {1'b0, ea} - s - cin : {1'b0, ea} + s + cin;
          ef.aux = hi == 4'h9 ? {1'b0, ea[3:0]} < s[3:0] + cin
                              : {1'b0, ea[3:0]} + s[3:0] + cin > 5'h0F;
          ef.ovf = (ea[7] ^ s[7] ^ (hi != 4'h9)) && t[7] != ea[7];
          ef.carry = t[8];
          ea = t[7:0];
        end
        r = hi == 4'h5 ? d & t2 : hi == 4'h4 ? d | t2 : d ^ t2;
        if (lg && lo[3:1] == 3'h1)
          ew = '{1'b1, b1, r};
        else if (lg)
          ea = r;
      end
    endcase
    // bytes offered while fetch is open
    for (int i = 0; i < n; i++)
    begin
      check("ready", ready, 1'b1);
      code = '{1'b1, bytes[i]};
      @(negedge i_clock);
    end
    code.valid = 1'b0;
    // count cycles up to the end pulse, catching any write on the way
    for (k = 1; k < 12; k++)
    begin
      if (wr.valid === 1'b1)
        seen_wr = wr;
      if (done.valid === 1'b1)
        break;
      @(negedge i_clock);
    end
    if (k == 12)
    begin
      errors++;
      close_out();
    end
    check("cycles", 20'(k), cy + 3'h1);
    check("opcode", done.opcode, op);
    check("bytes", done.bytes, n);
    check("cycle count", done.cycles, cy);
    check("legal", done.legal, el || op inside {8'h23, 8'h33, 8'h03,
          8'h13, 8'hC4, 8'hA4, 8'h84});
    check("acc", acc, ea);
    check("write", seen_wr, ew);
    check("carry ovf", {flags.carry, flags.ovf}, {ef.carry, ef.ovf});
    if (ar)
      check("aux", flags.aux, ef.aux);
  endtask

  // every addressing form of the three arithmetic groups
  task automatic arith_ops;
    logic [3:0] ga [3] = '{4'h2, 4'h3, 4'h9};
    logic [3:0] ma [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};
    foreach (ga[g])
      foreach (ma[m])
        step({ga[g], ma[m]}, 8'h9B, 8'h00);
  endtask

  // logic groups into the accumulator and into a direct byte
  task automatic logic_ops;
    logic [3:0] gl [3] = '{4'h5, 4'h4, 4'h6};
    logic [3:0] ml [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hE};
    foreach (gl[g])
      foreach (ml[m])
        step({gl[g], ml[m]}, 8'h47, 8'hB6);
  endtask

  // rotates and the nibble swap twice round so the carry ring is exercised both ways
  task automatic rotate_ops;
    logic [7:0] ops [5] = '{8'h23, 8'h33, 8'h03, 8'h13, 8'hC4};
    repeat (2)
      foreach (ops[i])
        step(ops[i], 8'h00, 8'h00);
  endtask

  // an OR immediate to load the accumulator, long operations, then an opcode outside this group
  task automatic long_ops;
    step(8'h44, 8'hFF, 8'h00);
    step(8'hA4, 8'h00, 8'h00);
    step(8'h84, 8'h00, 8'h00);
    step(8'hA5, 8'h00, 8'h00);
  endtask

  // reset for five cycles, then the scenarios back to back
  initial
  begin
    repeat (5) @(negedge i_clock);
    i_reset_n = 1'b1;
    check("reset acc", acc, RST_ACC);
    arith_ops();
    logic_ops();
    rotate_ops();
    long_ops();
    close_out();
  end
endmodule
`default_nettype wire
